/* File: core/lpmc_pkg.sv */
package lpmc_pkg;
    // wake vectors (high byte address of each vector pair)
    localparam logic [15:0] VEC_RESET    = 16'h1ffe;
    localparam logic [15:0] VEC_EXT_IRQ  = 16'h1ffa;
    localparam logic [15:0] VEC_CORE_TCK = 16'h1ff8;
    localparam logic [15:0] VEC_PTIMER   = 16'h1ff6;
    localparam logic [15:0] VEC_SERIAL   = 16'h1ff4;
    localparam logic [15:0] VEC_ANALOG   = 16'h1ff2;
    // recovery delays in internal bus cycles
    localparam int unsigned DLY_SHORT_CYC = 16;
    localparam int unsigned DLY_LONG_CYC  = 4064;
    localparam int          DLY_W         = 12;
    localparam logic [DLY_W-1:0] DLY_SHORT = DLY_W'(DLY_SHORT_CYC);
    localparam logic [DLY_W-1:0] DLY_LONG  = DLY_W'(DLY_LONG_CYC);
    localparam int          PA_IRQ_W      = 4;
    localparam int          SYNC_STAGES   = 3;

    typedef enum logic [2:0] {
        LPMC_RUN     = 3'b000,
        LPMC_STOP    = 3'b001,
        LPMC_WAIT    = 3'b010,
        LPMC_HALT    = 3'b011,
        LPMC_RECOVER = 3'b100
    } lpmc_state_t;
endpackage

/* File: core/lpmc_pin_sync.sv */
`timescale 1ns/1ps
// three-stage synchroniser; change counts when stages two and three agree
module lpmc_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clock,   // bus clock
    input  wire logic         i_sys_rst, // sync reset, high
    input  wire logic [W-1:0] i_async,   // raw pins
    input  wire logic [W-1:0] i_rst_val, // value held during reset
    output logic      [W-1:0] o_level    // filtered level
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] lvl_ff;

    always_ff @(posedge i_clock) begin
        s1_ff <= i_async;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
    end

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_clock) begin
                if (i_sys_rst) begin
                    lvl_ff[g] <= i_rst_val[g];
                end else if (s2_ff[g] == s3_ff[g]) begin
                    lvl_ff[g] <= s3_ff[g];
                end
            end
        end
    endgenerate

    assign o_level = lvl_ff;
endmodule

/* File: core/lpmc_delay_cnt.sv */
`timescale 1ns/1ps
// recovery counter: loads a terminal count, pulses done on reaching it
module lpmc_delay_cnt #(
    parameter int W = lpmc_pkg::DLY_W
) (
    input  wire logic         i_clock,   // bus clock
    input  wire logic         i_sys_rst, // sync reset, high
    input  wire logic         i_start,   // begin counting
    input  wire logic [W-1:0] i_limit,   // terminal count, at least 1
    output logic              o_busy,    // counting
    output logic              o_done     // one-cycle pulse at terminal count
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] lim_ff;
    logic         busy_ff;
    logic         done_ff;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cnt_ff  <= '0;
            lim_ff  <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (i_start) begin
            cnt_ff  <= W'(1);
            lim_ff  <= i_limit;
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
        end else if (busy_ff && cnt_ff >= lim_ff) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
        end else begin
            cnt_ff  <= busy_ff ? cnt_ff + W'(1) : cnt_ff;
            done_ff <= 1'b0;
        end
    end

    assign o_busy = busy_ff;
    assign o_done = done_ff;
endmodule

/* File: core/lpmc_low_power_ctrl.sv */
`timescale 1ns/1ps
module lpmc_low_power_ctrl (
    input  wire logic        i_clock,          // bus clock, 125 MHz
    input  wire logic        i_sys_rst,        // sync reset, high
    input  wire logic        i_reset_pin_n,    // external reset pin, low active
    input  wire logic        i_irq_pin_n,      // interrupt pin, falling edge
    input  wire logic [3:0]  i_pa_irq_pins,    // port A low pins, rising edge
    input  wire logic        i_opt_pa_irq,     // port A interrupt option
    input  wire logic        i_opt_halt,       // stop acts as halt
    input  wire logic        i_opt_long_dly,   // startup delay 4064 else 16
    input  wire logic        i_stop_exec,      // CPU executes stop, pulse
    input  wire logic        i_wait_exec,      // CPU executes wait, pulse
    input  wire logic        i_core_tick_irq,  // core tick interrupt request
    input  wire logic        i_ptimer_irq,     // programmable timer request
    input  wire logic        i_serial_irq,     // serial transfer done request
    input  wire logic        i_analog_irq,     // analog comparison request
    input  wire logic        i_watchdog_tmo,   // watchdog timeout pulse
    output logic             o_cpu_clk_en,     // CPU bus clock enable
    output logic             o_osc_run,        // oscillators running
    output logic             o_periph_clk_en,  // timers, analog, serial clocks
    output logic             o_watchdog_run,   // watchdog clocked
    output logic             o_clr_core_tick,  // clear core tick flags/enables
    output logic             o_clr_ptimer,     // clear ptimer flags/enables
    output logic             o_set_ext_irq_en, // set ext_irq_enable pulse
    output logic             o_clr_imask,      // clear global mask pulse
    output logic             o_wake,           // wake pulse; after wait the vector follows it by one cycle
    output logic [15:0]      o_wake_vector,    // vector address
    output logic             o_dev_reset,      // device reset request
    output logic [2:0]       o_state           // current mode
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic       irq_lvl;
    logic [3:0] pa_lvl;
    logic       rst_lvl;
    logic       irq_prev_ff;
    logic [3:0] pa_prev_ff;

    lpmc_pin_sync #(.W(6)) u_sync (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_reset_pin_n, i_irq_pin_n, i_pa_irq_pins}),
        .i_rst_val (6'h30),
        .o_level   ({rst_lvl, irq_lvl, pa_lvl})
    );

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            irq_prev_ff <= 1'b1;
            pa_prev_ff  <= 4'h0;
        end else begin
            irq_prev_ff <= irq_lvl;
            pa_prev_ff  <= pa_lvl;
        end
    end

    logic ext_edge;
    assign ext_edge = (irq_prev_ff & ~irq_lvl)
                    | (i_opt_pa_irq & |(pa_lvl & ~pa_prev_ff));
    logic pin_reset;
    assign pin_reset = ~rst_lvl;

    ////////////////////////////////////////////////////////////////////////
    // wake source priority
    function automatic logic [15:0] wait_vec(input logic e, input logic c,
                                             input logic p, input logic s);
        if (e)      wait_vec = lpmc_pkg::VEC_EXT_IRQ;
        else if (c) wait_vec = lpmc_pkg::VEC_CORE_TCK;
        else if (p) wait_vec = lpmc_pkg::VEC_PTIMER;
        else if (s) wait_vec = lpmc_pkg::VEC_SERIAL;
        else        wait_vec = lpmc_pkg::VEC_ANALOG;
    endfunction

    logic any_wait_src;
    assign any_wait_src = ext_edge | i_core_tick_irq | i_ptimer_irq
                        | i_serial_irq | i_analog_irq;

    ////////////////////////////////////////////////////////////////////////
    // mode state machine
    lpmc_pkg::lpmc_state_t state_ff;
    lpmc_pkg::lpmc_state_t nxt_state;
    logic [15:0]           vec_ff;
    logic                  dly_start;
    logic                  dly_busy;
    logic                  dly_done;
    logic [lpmc_pkg::DLY_W-1:0] dly_limit;

    assign dly_limit = i_opt_long_dly ? lpmc_pkg::DLY_LONG : lpmc_pkg::DLY_SHORT;

    lpmc_delay_cnt #(.W(lpmc_pkg::DLY_W)) u_dly (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_start   (dly_start),
        .i_limit   (dly_limit),
        .o_busy    (dly_busy),
        .o_done    (dly_done)
    );

    logic hard_reset;
    assign hard_reset = pin_reset | (i_watchdog_tmo & o_watchdog_run);

    always_comb begin
        nxt_state = state_ff;
        dly_start = 1'b0;
        case (state_ff)
            lpmc_pkg::LPMC_RUN: begin
                if (i_stop_exec) begin
                    nxt_state = i_opt_halt ? lpmc_pkg::LPMC_HALT
                                           : lpmc_pkg::LPMC_STOP;
                end else if (i_wait_exec) begin
                    nxt_state = lpmc_pkg::LPMC_WAIT;
                end
            end
            lpmc_pkg::LPMC_STOP: begin
                if (ext_edge) begin
                    nxt_state = lpmc_pkg::LPMC_RECOVER;
                    dly_start = 1'b1;
                end
            end
            lpmc_pkg::LPMC_WAIT: begin
                if (any_wait_src) begin
                    nxt_state = lpmc_pkg::LPMC_RUN;
                end
            end
            lpmc_pkg::LPMC_HALT: begin
                if (any_wait_src) begin
                    nxt_state = lpmc_pkg::LPMC_RECOVER;
                    dly_start = 1'b1;
                end
            end
            lpmc_pkg::LPMC_RECOVER: begin
                if (dly_done) begin
                    nxt_state = lpmc_pkg::LPMC_RUN;
                end
            end
            default: begin
                nxt_state = lpmc_pkg::LPMC_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst || hard_reset) begin
            state_ff <= lpmc_pkg::LPMC_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // vector captured at the wake event, shown on o_wake_vector one cycle later
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            vec_ff <= lpmc_pkg::VEC_RESET;
        end else if (hard_reset) begin
            vec_ff <= lpmc_pkg::VEC_RESET;
        end else if (state_ff == lpmc_pkg::LPMC_STOP && ext_edge) begin
            vec_ff <= lpmc_pkg::VEC_EXT_IRQ;
        end else if ((state_ff == lpmc_pkg::LPMC_WAIT
                      || state_ff == lpmc_pkg::LPMC_HALT) && any_wait_src) begin
            vec_ff <= wait_vec(ext_edge, i_core_tick_irq, i_ptimer_irq, i_serial_irq);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // entry side effects, one-cycle pulses
    logic entering_stop;
    logic entering_any;
    assign entering_stop = (state_ff == lpmc_pkg::LPMC_RUN) && i_stop_exec && !i_opt_halt;
    assign entering_any  = (state_ff == lpmc_pkg::LPMC_RUN) && (i_stop_exec || i_wait_exec);

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_clr_core_tick  <= 1'b0;
            o_clr_ptimer     <= 1'b0;
            o_set_ext_irq_en <= 1'b0;
            o_clr_imask      <= 1'b0;
        end else begin
            o_clr_core_tick  <= entering_stop && !hard_reset;
            o_clr_ptimer     <= entering_stop && !hard_reset;
            o_set_ext_irq_en <= entering_any && !hard_reset;
            o_clr_imask      <= entering_any && !hard_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock gating and wake outputs
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_cpu_clk_en    <= 1'b1;
            o_osc_run       <= 1'b1;
            o_periph_clk_en <= 1'b1;
            o_watchdog_run  <= 1'b1;
            o_wake          <= 1'b0;
            o_wake_vector   <= lpmc_pkg::VEC_RESET;
            o_dev_reset     <= 1'b0;
            o_state         <= 3'h0;
        end else begin
            o_cpu_clk_en    <= (nxt_state == lpmc_pkg::LPMC_RUN) || hard_reset;
            o_osc_run       <= (nxt_state != lpmc_pkg::LPMC_STOP) || hard_reset;
            o_periph_clk_en <= (nxt_state != lpmc_pkg::LPMC_STOP) || hard_reset;
            o_watchdog_run  <= (nxt_state != lpmc_pkg::LPMC_STOP) || hard_reset;
            o_wake          <= !hard_reset && state_ff != lpmc_pkg::LPMC_RUN
                               && nxt_state == lpmc_pkg::LPMC_RUN;
            o_wake_vector   <= hard_reset ? lpmc_pkg::VEC_RESET : vec_ff;
            o_dev_reset     <= hard_reset;
            o_state         <= hard_reset ? 3'h0 : nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_stop_clears_flags: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (entering_stop && !hard_reset) |=> (o_clr_core_tick && o_clr_ptimer))
        else $error("stop entry did not clear timer flags");

    a_halt_osc_on: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (state_ff == lpmc_pkg::LPMC_HALT) |=> o_osc_run)
        else $error("oscillator stopped in halt");

    a_stop_osc_off: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (state_ff == lpmc_pkg::LPMC_STOP && !ext_edge && !hard_reset) |=> !o_osc_run)
        else $error("oscillator running in stop");

    a_wait_fast_exit: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (state_ff == lpmc_pkg::LPMC_WAIT && any_wait_src && !hard_reset)
        |=> (o_cpu_clk_en && o_wake))
        else $error("wait exit delayed");

    sequence s_stop_wake;
        state_ff == lpmc_pkg::LPMC_STOP && ext_edge && !hard_reset
        && !i_opt_long_dly;
    endsequence
    a_stop_short_dly: assert property (@(posedge i_clock) disable iff (i_sys_rst || hard_reset)
        s_stop_wake |=> !o_cpu_clk_en [*8] ##9 !o_cpu_clk_en ##1 o_cpu_clk_en)
        else $error("stop recovery delay wrong");

    a_wait_core_vec: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (state_ff == lpmc_pkg::LPMC_WAIT && i_core_tick_irq && !ext_edge && !hard_reset)
        |=> ##1 (o_wake_vector == lpmc_pkg::VEC_CORE_TCK))
        else $error("core tick vector wrong");

    a_wdog_reset_vec: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_watchdog_tmo && o_watchdog_run)
        |=> (o_dev_reset && o_wake_vector == lpmc_pkg::VEC_RESET))
        else $error("watchdog reset missing");

    a_entry_mask_clr: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (entering_any && !hard_reset) |=> (o_clr_imask && o_set_ext_irq_en))
        else $error("entry side effects missing");

    a_wait_no_clear: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (state_ff == lpmc_pkg::LPMC_RUN && i_wait_exec && !i_stop_exec) |=> !o_clr_ptimer)
        else $error("wait cleared timer state");

    a_wait_clocks_on: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (state_ff == lpmc_pkg::LPMC_WAIT) |-> (o_osc_run && o_periph_clk_en && !o_cpu_clk_en))
        else $error("wait gated the wrong clocks");

    a_stop_clocks_off: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (entering_stop && !hard_reset)
        |=> (!o_osc_run && !o_periph_clk_en && !o_watchdog_run && !o_cpu_clk_en))
        else $error("stop left a clock running");

    a_halt_no_clear: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (state_ff == lpmc_pkg::LPMC_RUN && i_stop_exec && i_opt_halt)
        |=> (!o_clr_core_tick && !o_clr_ptimer))
        else $error("halt entry cleared timer state");

    a_wait_ptimer_vec: assert property (@(posedge i_clock)
        disable iff (i_sys_rst || hard_reset)
        (state_ff == lpmc_pkg::LPMC_WAIT && i_ptimer_irq && !i_core_tick_irq && !ext_edge)
        |=> ##1 (o_wake_vector == lpmc_pkg::VEC_PTIMER))
        else $error("programmable timer vector wrong");

    a_wait_serial_vec: assert property (@(posedge i_clock)
        disable iff (i_sys_rst || hard_reset)
        (state_ff == lpmc_pkg::LPMC_WAIT && i_serial_irq && !i_ptimer_irq
         && !i_core_tick_irq && !ext_edge)
        |=> ##1 (o_wake_vector == lpmc_pkg::VEC_SERIAL))
        else $error("serial vector wrong");

    a_wait_analog_vec: assert property (@(posedge i_clock)
        disable iff (i_sys_rst || hard_reset)
        (state_ff == lpmc_pkg::LPMC_WAIT && i_analog_irq && !i_serial_irq && !i_ptimer_irq
         && !i_core_tick_irq && !ext_edge)
        |=> ##1 (o_wake_vector == lpmc_pkg::VEC_ANALOG))
        else $error("analog vector wrong");

    sequence s_halt_wake;
        state_ff == lpmc_pkg::LPMC_HALT && any_wait_src && !hard_reset
        && !i_opt_long_dly;
    endsequence
    a_halt_short_dly: assert property (@(posedge i_clock)
        disable iff (i_sys_rst || hard_reset)
        s_halt_wake |=> !o_cpu_clk_en [*8] ##9 !o_cpu_clk_en ##1 o_cpu_clk_en)
        else $error("halt recovery delay wrong");

    a_ext_wake_vec: assert property (@(posedge i_clock)
        disable iff (i_sys_rst || hard_reset)
        (state_ff == lpmc_pkg::LPMC_STOP && ext_edge)
        |=> ##1 (o_wake_vector == lpmc_pkg::VEC_EXT_IRQ))
        else $error("external wake vector wrong");

    a_pin_reset_run: assert property (@(posedge i_clock)
        disable iff (i_sys_rst)
        pin_reset |=> (o_dev_reset && o_state == 3'h0 && o_osc_run && o_cpu_clk_en))
        else $error("pin reset did not force run");
endmodule

/* File: tb/lpmc_cpu_model.sv */
`timescale 1ns/1ps
// cpu core plus the peripheral request sources
module lpmc_cpu_model (
    input  wire logic       i_clock, // bus clock
    input  wire logic       i_wake,  // wake pulse
    output logic            o_stop,  // stop executed
    output logic            o_wait,  // wait executed
    output logic [3:0]      o_irq,   // tick, ptimer, serial, analog
    output logic            o_wdog   // watchdog timeout
);
    initial begin
        o_stop = 1'b0;
        o_wait = 1'b0;
        o_irq  = 4'h0;
        o_wdog = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // handler clears the pending flag once the cpu runs again
    always @(posedge i_clock) begin
        if (i_wake)
            o_irq <= 4'h0;
    end
    ////////////////////////////////////////////////////////////////
    // one-cycle pulse: 0 stop, 1 wait, 2 watchdog
    task automatic pulse(input int sel);
        @(posedge i_clock);
        #1;
        o_stop = (sel == 0);
        o_wait = (sel == 1);
        o_wdog = (sel == 2);
        @(posedge i_clock);
        #1;
        {o_stop, o_wait, o_wdog} = 3'h0;
    endtask
    // request level stays up until serviced
    task automatic raise(input int idx);
        @(posedge i_clock);
        #1;
        o_irq[idx] = 1'b1;
    endtask
endmodule

/* File: tb/low_power_mode_control_test.sv */
`timescale 1ns/1ps
module low_power_mode_control_test;
    logic        i_clock, i_sys_rst, rst_pin_n, irq_pin_n, opt_pa, opt_halt, opt_long;
    logic        stop_x, wait_x, wdog_tmo, clk_en, osc, periph, wdog_run;
    logic        clr_tick, clr_ptm, set_ext, clr_imask, wake, dev_rst;
    logic [3:0]  pa_pins, irqs;
    logic [15:0] vec;
    logic [2:0]  state;
    logic [15:0] vecs [4];
    int          n_errors, check_count;

    always #4 i_clock = ~i_clock;

    lpmc_low_power_ctrl uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_reset_pin_n(rst_pin_n), .i_irq_pin_n(irq_pin_n), .i_pa_irq_pins(pa_pins),
        .i_opt_pa_irq(opt_pa), .i_opt_halt(opt_halt), .i_opt_long_dly(opt_long),
        .i_stop_exec(stop_x), .i_wait_exec(wait_x), .i_core_tick_irq(irqs[0]),
        .i_ptimer_irq(irqs[1]), .i_serial_irq(irqs[2]), .i_analog_irq(irqs[3]),
        .i_watchdog_tmo(wdog_tmo), .o_cpu_clk_en(clk_en), .o_osc_run(osc),
        .o_periph_clk_en(periph), .o_watchdog_run(wdog_run), .o_clr_core_tick(clr_tick),
        .o_clr_ptimer(clr_ptm), .o_set_ext_irq_en(set_ext), .o_clr_imask(clr_imask),
        .o_wake(wake), .o_wake_vector(vec), .o_dev_reset(dev_rst), .o_state(state));

    lpmc_cpu_model cpu (.i_clock(i_clock), .i_wake(wake), .o_stop(stop_x),
        .o_wait(wait_x), .o_irq(irqs), .o_wdog(wdog_tmo));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////
    // plain: stop without halt option
    task automatic enter(input logic stp, input logic plain);
        cpu.pulse(stp ? 0 : 1);
        check(16'(state), plain ? 16'h1 : (stp ? 16'h3 : 16'h2));
        check(16'(clk_en), 16'h0);
        check(16'({osc, periph}), plain ? 16'h0 : 16'h3);
        check(16'(wdog_run), 16'(!plain));
        check(16'(clr_tick), 16'(plain));
        check(16'(clr_ptm), 16'(plain));
        check(16'({set_ext, clr_imask}), 16'h3);
        tick(1);
        check(16'({clr_tick, clr_ptm, set_ext, clr_imask}), 16'h0);
    endtask

    task automatic await_wake(input logic [15:0] v, input int rec, input int lim);
        int n;
        int k;
        n = 0;
        for (k = 0; k < 5000 && wake !== 1'b1; k++) begin
            if (state === lpmc_pkg::LPMC_RECOVER)
                n++;
            tick(1);
        end
        check(16'({wake, clk_en}), 16'h3);
        check(16'(k <= lim), 16'h1);
        check(16'(n), 16'(rec));
        check(16'({osc, periph, wdog_run}), 16'h7);
        tick(1);
        check(vec, v);
        check(16'(state), 16'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_errors++;
        test_done();
    end

    initial begin
        vecs = '{lpmc_pkg::VEC_CORE_TCK, lpmc_pkg::VEC_PTIMER,
                 lpmc_pkg::VEC_SERIAL, lpmc_pkg::VEC_ANALOG};
        {i_clock, rst_pin_n, irq_pin_n, opt_pa, opt_halt, opt_long} = 6'h1c;
        pa_pins = 4'h0;
        i_sys_rst = 1'b1;
        n_errors = 0;
        check_count = 0;
        tick(4);
        i_sys_rst = 1'b0;
        tick(4);
        check(16'({clk_en, osc, periph, wdog_run}), 16'hf);
        check(vec, lpmc_pkg::VEC_RESET);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            enter(1'b0, 1'b0);
            cpu.raise(i);
            await_wake(vecs[i], 0, 1);
        end
        enter(1'b0, 1'b0);
        irq_pin_n = 1'b0;
        await_wake(lpmc_pkg::VEC_EXT_IRQ, 0, 6);
        irq_pin_n = 1'b1;
        tick(6);
        enter(1'b0, 1'b0);
        opt_pa = 1'b0;
        pa_pins = 4'h1;
        tick(8);
        check(16'({state, wake}), 16'h4);
        pa_pins = 4'h0;
        opt_pa = 1'b1;
        tick(6);
        cpu.pulse(2);
        check(16'(dev_rst), 16'h1);
        tick(3);
        check(vec, lpmc_pkg::VEC_RESET);
        $display("test wait done");
        enter(1'b1, 1'b1);
        cpu.raise(0);
        cpu.pulse(2);
        tick(4);
        check(16'({state, dev_rst}), 16'h2);
        pa_pins = 4'h4;
        await_wake(lpmc_pkg::VEC_EXT_IRQ, 17, 30);
        pa_pins = 4'h0;
        opt_long = 1'b1;
        tick(6);
        enter(1'b1, 1'b1);
        irq_pin_n = 1'b0;
        await_wake(lpmc_pkg::VEC_EXT_IRQ, 4065, 4080);
        irq_pin_n = 1'b1;
        tick(6);
        enter(1'b1, 1'b1);
        rst_pin_n = 1'b0;
        tick(8);
        check(16'({dev_rst, osc, state}), 16'h18);
        rst_pin_n = 1'b1;
        tick(8);
        check(vec, lpmc_pkg::VEC_RESET);
        $display("test stop done");
        {opt_halt, opt_long} = 2'h2;
        enter(1'b1, 1'b0);
        cpu.raise(1);
        await_wake(lpmc_pkg::VEC_PTIMER, 17, 20);
        enter(1'b1, 1'b0);
        cpu.pulse(2);
        check(16'(dev_rst), 16'h1);
        tick(3);
        $display("test halt done");
        test_done();
    end
endmodule
